// ### design/sdcd_regs.vh
// Register offsets, fields, reset values and counts of the sigma-delta clock and decimator
`ifndef SDCD_REGS_VH
`define SDCD_REGS_VH
`define SDCD_ADDR_CLKDIV   8'hf7
`define SDCD_ADDR_DECH     8'h9b
`define SDCD_ADDR_DECL     8'h9a
`define SDCD_ADDR_OFFSET   8'hf5
`define SDCD_ADDR_CTRL     8'hf6
`define SDCD_RST_CLKDIV    8'h00
`define SDCD_RST_DECH      3'h7
`define SDCD_RST_DECL      8'hff
`define SDCD_RST_OFFSET    8'h00
`define SDCD_RST_CTRL      6'h00
`define SDCD_CTRL_CONV     0
`define SDCD_CTRL_WORD24   1
`define SDCD_CTRL_HI_EN    2
`define SDCD_CTRL_HI_BYP   3
`define SDCD_CTRL_LO_EN    4
`define SDCD_CTRL_LO_BYP   5
`define SDCD_CTRL_BUSY     7
`define SDCD_SAMPLE_LEN    7'h7f
`define SDCD_DECIMATION_SETTING_MIN      11'h013
`endif

// ### design/sdcd_accum.v
// One sinc integrator stage
`timescale 1ns/10ps
module sdcd_accum #(
	parameter W = 36
) (
	input  wire         clk,
	input  wire         rst,
	input  wire         clr,
	input  wire         en,
	input  wire [W-1:0] din,
	output wire [W-1:0] acc
);
	reg [W-1:0] acc_ff;
	reg [W-1:0] nxt_acc;

	always @* begin
		nxt_acc = acc_ff;
		if (clr)
			nxt_acc = {W{1'b0}};
		else if (en)
			nxt_acc = acc_ff + din;
	end

	always @(posedge clk) begin
		if (rst)
			acc_ff <= {W{1'b0}};
		else
			acc_ff <= nxt_acc;
	end

	assign acc = acc_ff;
endmodule // sdcd_accum

// ### design/sdcd_top.v
// Modulator clock divider, sample timing and third-order sinc decimator with control registers
`timescale 1ns/10ps
`include "sdcd_regs.vh"
module sdcd_top #(
	parameter W = 36
) (
	input  wire        SYS_CLK,
	input  wire        RST,
	input  wire [7:0]  SFR_ADDR,
	input  wire [7:0]  SFR_WDATA,
	input  wire        SFR_WR,
	input  wire        SFR_RD,
	output wire [7:0]  SFR_RDATA,
	input  wire        MOD_BIT,
	output wire        MOD_CLK,
	output wire [23:0] RESULT,
	output wire        WORD_VALID,
	output wire        BUF_HI_EN,
	output wire        BUF_HI_BYP,
	output wire        BUF_LO_EN,
	output wire        BUF_LO_BYP
);
	reg  [7:0]    clkdiv_ff;
	reg  [2:0]    dech_ff;
	reg  [7:0]    decl_ff;
	reg  [7:0]    offset_ff;
	reg  [5:0]    ctrl_ff;
	reg  [7:0]    rdata_ff;
	reg  [7:0]    div_cnt_ff;
	reg           mod_clk_ff;
	reg  [6:0]    smp_cnt_ff;
	reg  [10:0]   dec_cnt_ff;
	reg           bit_s1_ff;
	reg           bit_s2_ff;
	reg  [W-1:0]  d1_ff;
	reg  [W-1:0]  d2_ff;
	reg  [W-1:0]  d3_ff;
	reg  [23:0]   result_ff;
	reg           valid_ff;
	reg  [3:0]    buf_ff;
	reg  [7:0]    nxt_rdata;
	wire          conv;
	wire          md_tick;
	wire          smp_tick;
	wire          word_tick;
	wire [10:0]   decimation_setting;
	wire [10:0]   decimation_setting_eff;
	wire [8:0]    half;
	wire [W-1:0]  x_in;
	wire [W-1:0]  i1;
	wire [W-1:0]  i2;
	wire [W-1:0]  i3;
	wire [W-1:0]  c1;
	wire [W-1:0]  c2;
	wire [W-1:0]  c3;
	wire [23:0]   raw24;
	wire [23:0]   adj24;
	wire [23:0]   off24;

	assign conv = ctrl_ff[`SDCD_CTRL_CONV];

	// Register writes
	always @(posedge SYS_CLK) begin
		if (RST) begin
			clkdiv_ff <= `SDCD_RST_CLKDIV;
			dech_ff   <= `SDCD_RST_DECH;
			decl_ff   <= `SDCD_RST_DECL;
			offset_ff <= `SDCD_RST_OFFSET;
			ctrl_ff   <= `SDCD_RST_CTRL;
		end else if (SFR_WR) begin
			case (SFR_ADDR)
				`SDCD_ADDR_CLKDIV: clkdiv_ff <= SFR_WDATA;
				`SDCD_ADDR_DECH: begin
					if (!conv)
						dech_ff <= SFR_WDATA[2:0];
				end
				`SDCD_ADDR_DECL: begin
					if (!conv)
						decl_ff <= SFR_WDATA;
				end
				`SDCD_ADDR_OFFSET: offset_ff <= SFR_WDATA;
				`SDCD_ADDR_CTRL: ctrl_ff <= SFR_WDATA[5:0];
				default: ctrl_ff <= ctrl_ff;
			endcase
		end
	end

	// Register reads
	always @* begin
		nxt_rdata = 8'h00;
		case (SFR_ADDR)
			`SDCD_ADDR_CLKDIV: nxt_rdata = clkdiv_ff;
			`SDCD_ADDR_DECH:   nxt_rdata = {5'h00, dech_ff};
			`SDCD_ADDR_DECL:   nxt_rdata = decl_ff;
			`SDCD_ADDR_OFFSET: nxt_rdata = offset_ff;
			`SDCD_ADDR_CTRL:   nxt_rdata = {conv, 1'b0, ctrl_ff};
			default:           nxt_rdata = 8'h00;
		endcase
	end

	always @(posedge SYS_CLK) begin
		if (RST)
			rdata_ff <= 8'h00;
		else if (SFR_RD)
			rdata_ff <= nxt_rdata;
	end

	// Modulator clock divider
	assign md_tick = (div_cnt_ff == clkdiv_ff);
	assign half    = ({1'b0, clkdiv_ff} + 9'h001) >> 1;

	always @(posedge SYS_CLK) begin
		if (RST) begin
			div_cnt_ff <= 8'h00;
			mod_clk_ff <= 1'b0;
		end else begin
			div_cnt_ff <= md_tick ? 8'h00 : div_cnt_ff + 8'h01;
			mod_clk_ff <= ({1'b0, div_cnt_ff} < half) || (clkdiv_ff == 8'h00);
		end
	end

	// Modulator bit synchroniser
	always @(posedge SYS_CLK) begin
		if (RST) begin
			bit_s1_ff <= 1'b0;
			bit_s2_ff <= 1'b0;
		end else begin
			bit_s1_ff <= MOD_BIT;
			bit_s2_ff <= bit_s1_ff;
		end
	end

	// Sample and decimation counters
	assign smp_tick  = conv && md_tick && (smp_cnt_ff == `SDCD_SAMPLE_LEN);
	assign decimation_setting      = {dech_ff, decl_ff};
	assign decimation_setting_eff  = (decimation_setting < `SDCD_DECIMATION_SETTING_MIN) ? `SDCD_DECIMATION_SETTING_MIN : decimation_setting;
	assign word_tick = smp_tick && (dec_cnt_ff == decimation_setting_eff);

	always @(posedge SYS_CLK) begin
		if (RST || !conv) begin
			smp_cnt_ff <= 7'h00;
			dec_cnt_ff <= 11'h000;
		end else begin
			if (md_tick)
				smp_cnt_ff <= smp_cnt_ff + 7'h01;
			if (word_tick)
				dec_cnt_ff <= 11'h000;
			else if (smp_tick)
				dec_cnt_ff <= dec_cnt_ff + 11'h001;
		end
	end

	// Sinc3 integrators, one bit per sample
	assign x_in = {{(W-1){1'b0}}, bit_s2_ff};

	sdcd_accum #(.W(W)) u_int1 (
		.clk (SYS_CLK),
		.rst (RST),
		.clr (!conv),
		.en  (smp_tick),
		.din (x_in),
		.acc (i1)
	);
	sdcd_accum #(.W(W)) u_int2 (
		.clk (SYS_CLK),
		.rst (RST),
		.clr (!conv),
		.en  (smp_tick),
		.din (i1),
		.acc (i2)
	);
	sdcd_accum #(.W(W)) u_int3 (
		.clk (SYS_CLK),
		.rst (RST),
		.clr (!conv),
		.en  (smp_tick),
		.din (i2),
		.acc (i3)
	);

	// Sinc3 differentiators at the word rate
	assign c1 = i3 - d1_ff;
	assign c2 = c1 - d2_ff;
	assign c3 = c2 - d3_ff;

	always @(posedge SYS_CLK) begin
		if (RST || !conv) begin
			d1_ff <= {W{1'b0}};
			d2_ff <= {W{1'b0}};
			d3_ff <= {W{1'b0}};
		end else if (word_tick) begin
			d1_ff <= i3;
			d2_ff <= c1;
			d3_ff <= c2;
		end
	end

	// Word scaling, offset and width selection
	assign raw24 = c3[33:10];
	assign off24 = {offset_ff, 16'h0000};
	assign adj24 = raw24 + off24;

	always @(posedge SYS_CLK) begin
		if (RST) begin
			result_ff <= 24'h000000;
			valid_ff  <= 1'b0;
		end else begin
			valid_ff <= word_tick;
			if (word_tick) begin
				if (ctrl_ff[`SDCD_CTRL_WORD24])
					result_ff <= adj24;
				else
					result_ff <= {8'h00, adj24[23:8]};
			end
		end
	end

	// Input buffer controls
	always @(posedge SYS_CLK) begin
		if (RST)
			buf_ff <= 4'h0;
		else
			buf_ff <= ctrl_ff[5:2];
	end

	assign SFR_RDATA  = rdata_ff;
	assign MOD_CLK    = mod_clk_ff;
	assign RESULT     = result_ff;
	assign WORD_VALID = valid_ff;
	assign BUF_HI_EN  = buf_ff[0];
	assign BUF_HI_BYP = buf_ff[1];
	assign BUF_LO_EN  = buf_ff[2];
	assign BUF_LO_BYP = buf_ff[3];
endmodule // sdcd_top

// ### testbench/sdcd_top_asserts.sv
// Port checker of the sigma-delta clock and decimator
`timescale 1ns/10ps
module sdcd_asserts (
	input wire        SYS_CLK,
	input wire        RST,
	input wire [7:0]  SFR_ADDR,
	input wire [7:0]  SFR_WDATA,
	input wire        SFR_WR,
	input wire        SFR_RD,
	input wire [7:0]  SFR_RDATA,
	input wire        MOD_BIT,
	input wire        MOD_CLK,
	input wire [23:0] RESULT,
	input wire        WORD_VALID,
	input wire        BUF_HI_EN,
	input wire        BUF_HI_BYP,
	input wire        BUF_LO_EN,
	input wire        BUF_LO_BYP
);
	reg  [7:0]  div_ff;
	reg  [10:0] dec_ff;
	reg  [3:0]  stab_ff;
	reg  [26:0] gap_ff;
	reg         conv_ff;
	reg         seen_ff;
	wire        wdiv = SFR_WR && SFR_ADDR == 8'hf7;
	wire        wdec = SFR_WR && !conv_ff;
	wire [10:0] eff  = (dec_ff < 11'h013) ? 11'h013 : dec_ff;
	wire [11:0] r    = {1'b0, eff} + 12'h001;
	wire [26:0] per  = {8'h00, r, 7'h00} * ({19'h0, div_ff} + 27'h1);
	// Shadow of the registers that set the word timing
	always @(posedge SYS_CLK) begin
		if (RST) begin
			div_ff <= 8'h00;
			dec_ff <= 11'h7ff;
			stab_ff <= 4'h0;
			gap_ff <= 27'h0;
			conv_ff <= 1'b0;
			seen_ff <= 1'b0;
		end else begin
			if (wdiv)
				div_ff <= SFR_WDATA;
			stab_ff <= wdiv ? 4'h0 : stab_ff + {3'h0, stab_ff != 4'hf};
			if (SFR_WR && SFR_ADDR == 8'hf6)
				conv_ff <= SFR_WDATA[0];
			if (wdec && SFR_ADDR == 8'h9b)
				dec_ff[10:8] <= SFR_WDATA[2:0];
			if (wdec && SFR_ADDR == 8'h9a)
				dec_ff[7:0] <= SFR_WDATA;
			gap_ff <= (WORD_VALID || !conv_ff) ? 27'h0 : gap_ff + 27'h1;
			seen_ff <= conv_ff && (seen_ff || WORD_VALID);
		end
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	a_valid_pulse: assert property (WORD_VALID |=> !WORD_VALID)
		else $error("valid long");
	a_result_load: assert property ($changed(RESULT) |-> WORD_VALID)
		else $error("result moved");
	a_buf_follow: assert property (SFR_WR && SFR_ADDR == 8'hf6 |=> ##1
		{BUF_LO_BYP, BUF_LO_EN, BUF_HI_BYP, BUF_HI_EN} == $past(SFR_WDATA[5:2], 2))
		else $error("buffers");
	a_div_read: assert property (wdiv ##2 SFR_RD && SFR_ADDR == 8'hf7 |=>
		SFR_RDATA == $past(SFR_WDATA, 3)) else $error("divisor read");
	a_clk_div0: assert property (div_ff == 8'h00 && stab_ff > 4'h4 |-> MOD_CLK)
		else $error("clock div0");
	a_clk_div1: assert property (div_ff == 8'h01 && stab_ff > 4'h4 |->
		MOD_CLK != $past(MOD_CLK)) else $error("clock div1");
	a_word_gap: assert property (WORD_VALID && seen_ff |-> gap_ff == per - 27'h1)
		else $error("word gap");
	a_idle_quiet: assert property (!conv_ff && !$past(conv_ff) |-> !WORD_VALID)
		else $error("idle word");
	c_word: cover property (WORD_VALID && seen_ff);
	c_neg: cover property (WORD_VALID && RESULT[23]);
	c_toggle: cover property (div_ff == 8'h01 && $changed(MOD_CLK));
endmodule // sdcd_asserts
bind sdcd_top sdcd_asserts u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR),
	.SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
	.MOD_BIT(MOD_BIT), .MOD_CLK(MOD_CLK), .RESULT(RESULT), .WORD_VALID(WORD_VALID),
	.BUF_HI_EN(BUF_HI_EN), .BUF_HI_BYP(BUF_HI_BYP), .BUF_LO_EN(BUF_LO_EN),
	.BUF_LO_BYP(BUF_LO_BYP));

// ### testbench/sdcd_mod_model.sv
// Modulator model driving the one-bit stream
`timescale 1ns/10ps
module sdcd_mod_model (
	input  wire clk,
	input  wire level,
	output reg  mod_bit
);
	initial mod_bit = 1'b0;
	always @(posedge clk) begin
		mod_bit <= level;
	end
endmodule // sdcd_mod_model

// ### testbench/testbench.sv
// Register-level testbench of the sigma-delta clock and decimator
`timescale 1ns/10ps
`define CHK(m, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("Error %s expected %h seen %h", m, e, g); end end
module testbench;
	reg         SYS_CLK = 1'b0;
	reg         RST = 1'b1;
	reg  [7:0]  SFR_ADDR = 8'h00;
	reg  [7:0]  SFR_WDATA = 8'h00;
	reg         SFR_WR = 1'b0;
	reg         SFR_RD = 1'b0;
	wire [7:0]  SFR_RDATA;
	wire        MOD_BIT;
	wire        MOD_CLK;
	wire [23:0] RESULT;
	wire        WORD_VALID;
	wire [3:0]  bufs;
	reg  [7:0]  q;
	reg         lvl = 1'b0;
	int         err_total = 0;
	int         tests_run = 0;
	int         n;
	reg  [7:0]  ra [0:5] = '{8'hf7, 8'h9b, 8'h9a, 8'hf5, 8'hf6, 8'h33};
	reg  [7:0]  rv [0:5] = '{8'h00, 8'h07, 8'hff, 8'h00, 8'h00, 8'h00};
	always #25 SYS_CLK = ~SYS_CLK;
	sdcd_mod_model u_mod (.clk(SYS_CLK), .level(lvl), .mod_bit(MOD_BIT));
	sdcd_top dut (.SYS_CLK(SYS_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
		.SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .MOD_BIT(MOD_BIT),
		.MOD_CLK(MOD_CLK), .RESULT(RESULT), .WORD_VALID(WORD_VALID), .BUF_HI_EN(bufs[0]),
		.BUF_HI_BYP(bufs[1]), .BUF_LO_EN(bufs[2]), .BUF_LO_BYP(bufs[3]));
	task stop_test;
		$display("Checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		SFR_ADDR <= a;
		SFR_WDATA <= d;
		SFR_WR <= 1'b1;
		@(posedge SYS_CLK);
		SFR_WR <= 1'b0;
		@(posedge SYS_CLK);
	endtask
	task rd(input [7:0] a);
		SFR_ADDR <= a;
		SFR_RD <= 1'b1;
		@(posedge SYS_CLK);
		SFR_RD <= 1'b0;
		@(posedge SYS_CLK);
		q = SFR_RDATA;
	endtask
	// Wait for the next word strobe, counting cycles since the call
	task ww;
		n = 0;
		do begin
			@(posedge SYS_CLK);
			#1 n++;
			if (n > 21000) begin
				err_total++;
				stop_test;
			end
		end while (WORD_VALID !== 1'b1);
	endtask
	initial begin
		repeat (16) @(posedge SYS_CLK);
		RST <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(ra[i]);
			`CHK("reset value", rv[i], q)
		end
		wr(8'hf7, 8'h01);
		rd(8'hf7);
		`CHK("divisor", 8'h01, q)
		repeat (8) @(posedge SYS_CLK);
		wr(8'hf7, 8'h00);
		wr(8'h9b, 8'h00);
		wr(8'h9a, 8'h05);
		wr(8'hf5, 8'h80);
		wr(8'hf6, 8'h3f);
		wr(8'h9a, 8'h40);
		rd(8'h9a);
		`CHK("ratio", 8'h05, q)
		rd(8'hf6);
		`CHK("control", 8'hbf, q)
		`CHK("buffers", 4'hf, bufs)
		repeat (4) ww;
		`CHK("gap", 2560, n)
		`CHK("word24", 24'h800000, RESULT)
		@(posedge SYS_CLK);
		wr(8'hf6, 8'h3d);
		repeat (2) ww;
		`CHK("word16", 24'h008000, RESULT)
		@(posedge SYS_CLK);
		wr(8'hf6, 8'h00);
		repeat (3000) @(posedge SYS_CLK);
		`CHK("idle", 1'b0, WORD_VALID)
		// All-ones stream: settled sinc3 word is ratio cubed, 20^3 >> 10 = 7
		lvl <= 1'b1;
		wr(8'hf6, 8'h3f);
		repeat (5) ww;
		`CHK("ones gap", 2560, n)
		`CHK("ones word", 24'h800007, RESULT)
		// Divisor 7 gives 2.5 MHz, the nearest to the advised modulator clock
		wr(8'hf6, 8'h00);
		wr(8'hf7, 8'h07);
		wr(8'h9b, 8'h00);
		wr(8'h9a, 8'h13);
		rd(8'h9a);
		`CHK("ratio idle", 8'h13, q)
		wr(8'hf6, 8'h3f);
		repeat (2) ww;
		`CHK("slow gap", 20480, n)
		stop_test;
	end
endmodule // testbench
